// [rtl/dps_pkg.sv]
// Constants, register map and carriers of the drive position status block.
// Assumes a 250 MHz device clock and an APB master with 32-bit data.
package dps_pkg;

  // ==========================================================================
  // Register map (byte addresses).
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_TARGET  = 8'h04;
  localparam logic [7:0] ADDR_VEL     = 8'h08;
  localparam logic [7:0] ADDR_RAMP    = 8'h0c;
  localparam logic [7:0] ADDR_WIN     = 8'h10;
  localparam logic [7:0] ADDR_TOL     = 8'h14;
  localparam logic [7:0] ADDR_CFG     = 8'h18;
  localparam logic [7:0] ADDR_STAT_LO = 8'h20;
  localparam logic [7:0] ADDR_STAT_HI = 8'h24;

  // ==========================================================================
  // Control field positions.
  localparam int CW_ENABLE = 0;
  localparam int CW_ESTOP  = 2;
  localparam int CW_EXTFLT = 3;
  localparam int CW_FCLR   = 7;
  localparam int CW_DO1    = 14;
  localparam int CW_DO0    = 15;
  localparam int B2_AUTO   = 0;
  localparam int B2_START  = 1;
  localparam int B2_OVR    = 2;
  localparam int B2_FEED   = 3;
  localparam int B2_ABS    = 4;
  localparam int CFG_SERVO = 0;
  localparam int CFG_DCB   = 1;
  localparam int CFG_OFFL  = 2;

  // ==========================================================================
  // Reset values and limits.
  localparam logic [31:0] RST_VEL   = 32'h0001_0000;
  localparam logic [15:0] RST_RAMP  = 16'h0010;
  localparam logic [15:0] RST_WIN   = 16'h0010;
  localparam logic [15:0] RST_TOL   = 16'h1000;
  localparam logic [2:0]  RST_CFG   = 3'h1;
  localparam logic signed [31:0] VEL_MAX = 32'sh5000_0000;
  localparam logic signed [31:0] VEL_MIN = -32'sh5000_0000;
  localparam logic [31:0] TORQUE_STEP = 32'h0040_0000;

  // ==========================================================================
  // Timing.
  localparam int EVAL_TIME_NS = 1000000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int EVAL_CYC = EVAL_TIME_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 18;
  localparam logic [7:0] INIT_CYC  = 8'h10;
  localparam logic [7:0] DCB_TICKS = 8'h64;

  // ==========================================================================
  // Carriers.
  typedef struct packed {
    logic [7:0]  b3;
    logic [7:0]  b2;
    logic [15:0] w01;
  } dps_ctrl_t;

  typedef struct packed {
    logic [31:0] pos;
    logic [7:0]  b3;
    logic [7:0]  b2;
    logic [15:0] w01;
  } dps_status_t;

  typedef enum logic [2:0] {
    ST_INIT, ST_OFF, ST_RUN, ST_STOP, ST_ESTOP, ST_DCB
  } dps_state_t;

endpackage : dps_pkg

// [rtl/dps_status.sv]
// Drive position status word assembly and general control functions.
// Assumes APB from the host, encoder values on the device clock and
// asynchronous digital pins that are synchronised here.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module dps_status #(
  parameter int unsigned EVAL_CYCLES = dps_pkg::EVAL_CYC
) (
  input  wire logic               mclk_in,
  input  wire logic               rst_in,
  input  wire logic               psel_in,
  input  wire logic               penable_in,
  input  wire logic               pwrite_in,
  input  wire logic [7:0]         paddr_in,
  input  wire logic [31:0]        pwdata_in,
  output logic [31:0]             prdata_out,
  output logic                    pready_out,
  output logic                    pslverr_out,
  input  wire logic               hardware_enable_input_in,
  input  wire logic [3:0]         digital_input_in,
  input  wire logic               net_started_in,
  input  wire logic signed [31:0] measured_position_in,
  input  wire logic signed [31:0] measured_speed_in,
  output logic                    digital_output_0_out,
  output logic                    digital_output_1_out,
  output logic                    power_stage_on_out,
  output dps_pkg::dps_status_t    status_word_out
);

  // ==========================================================================
  // Pin synchronisers.
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  always_ff @(posedge mclk_in) begin
    pin_s1 <= {hardware_enable_input_in, digital_input_in};
    pin_s2 <= pin_s1;
  end
  wire       hw_en = pin_s2[4];
  wire [3:0] din   = pin_s2[3:0];

  // ==========================================================================
  // Registers.
  dps_pkg::dps_ctrl_t ctrl;
  logic [31:0]        target;
  logic signed [31:0] vel_ref;
  logic               vel_clamped;
  logic [15:0]        stop_ramp;
  logic [15:0]        still_win;
  logic [15:0]        follow_tol;
  logic               cfg_servo;
  logic               cfg_dcb;
  logic               offl_chg;

  wire setup = psel_in & ~penable_in;
  wire wr    = psel_in & penable_in & pwrite_in;
  wire hit_ctrl = paddr_in == dps_pkg::ADDR_CTRL;
  wire hit_tgt  = paddr_in == dps_pkg::ADDR_TARGET;
  wire hit_vel  = paddr_in == dps_pkg::ADDR_VEL;
  wire hit_ramp = paddr_in == dps_pkg::ADDR_RAMP;
  wire hit_win  = paddr_in == dps_pkg::ADDR_WIN;
  wire hit_tol  = paddr_in == dps_pkg::ADDR_TOL;
  wire hit_cfg  = paddr_in == dps_pkg::ADDR_CFG;
  wire hit_slo  = paddr_in == dps_pkg::ADDR_STAT_LO;
  wire hit_shi  = paddr_in == dps_pkg::ADDR_STAT_HI;
  wire hit_any  = hit_ctrl | hit_tgt | hit_vel | hit_ramp | hit_win
                | hit_tol | hit_cfg | hit_slo | hit_shi;

  wire signed [31:0] wvel = $signed(pwdata_in);
  wire wvel_hi = wvel > dps_pkg::VEL_MAX;
  wire wvel_lo = wvel < dps_pkg::VEL_MIN;
  wire reinit_go;

  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit_any;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl        <= '0;
      target      <= '0;
      vel_ref     <= dps_pkg::RST_VEL;
      vel_clamped <= 1'b0;
      stop_ramp   <= dps_pkg::RST_RAMP;
      still_win   <= dps_pkg::RST_WIN;
      follow_tol  <= dps_pkg::RST_TOL;
      cfg_servo   <= dps_pkg::RST_CFG[dps_pkg::CFG_SERVO];
      cfg_dcb     <= dps_pkg::RST_CFG[dps_pkg::CFG_DCB];
      offl_chg    <= dps_pkg::RST_CFG[dps_pkg::CFG_OFFL];
    end else begin
      if (wr && hit_ctrl) ctrl <= pwdata_in;
      if (wr && hit_tgt) target <= pwdata_in;
      if (wr && hit_vel) begin
        vel_ref     <= wvel_hi ? dps_pkg::VEL_MAX : (wvel_lo ? dps_pkg::VEL_MIN : wvel);
        vel_clamped <= wvel_hi | wvel_lo;
      end
      if (wr && hit_ramp) stop_ramp <= pwdata_in[15:0];
      if (wr && hit_win) still_win <= pwdata_in[15:0];
      if (wr && hit_tol) follow_tol <= pwdata_in[15:0];
      if (wr && hit_cfg) begin
        cfg_servo <= pwdata_in[dps_pkg::CFG_SERVO];
        cfg_dcb   <= pwdata_in[dps_pkg::CFG_DCB];
      end
      // A new offline change wins over the reinit that consumes the old one.
      if (wr && hit_cfg && pwdata_in[dps_pkg::CFG_OFFL]) offl_chg <= 1'b1;
      else if (reinit_go) offl_chg <= 1'b0;
    end
  end

  // ==========================================================================
  // Control bit decode and edge detection.
  wire en_bit   = ctrl.w01[dps_pkg::CW_ENABLE];
  wire ext_flt  = ctrl.w01[dps_pkg::CW_EXTFLT];
  wire auto_bit = ctrl.b2[dps_pkg::B2_AUTO];
  wire ovr_bit  = ctrl.b2[dps_pkg::B2_OVR];
  wire feed_ok  = ctrl.b2[dps_pkg::B2_FEED];
  wire abs_bit  = ctrl.b2[dps_pkg::B2_ABS];
  logic estop_q;
  logic fclr_q;
  logic start_q;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      estop_q <= 1'b0;
      fclr_q  <= 1'b0;
      start_q <= 1'b0;
    end else begin
      estop_q <= ctrl.w01[dps_pkg::CW_ESTOP];
      fclr_q  <= ctrl.w01[dps_pkg::CW_FCLR];
      start_q <= ctrl.b2[dps_pkg::B2_START];
    end
  end
  wire estop_rise = ctrl.w01[dps_pkg::CW_ESTOP] & ~estop_q;
  wire fclr_rise  = ctrl.w01[dps_pkg::CW_FCLR] & ~fclr_q;
  wire start_rise = ctrl.b2[dps_pkg::B2_START] & ~start_q;

  // ==========================================================================
  // Evaluation tick.
  logic [dps_pkg::TICK_W-1:0] tick_cnt;
  wire tick = tick_cnt == dps_pkg::TICK_W'(EVAL_CYCLES - 1);
  always_ff @(posedge mclk_in) begin
    if (rst_in || tick) tick_cnt <= '0;
    else tick_cnt <= tick_cnt + 1'b1;
  end

  // ==========================================================================
  // Fault flag; a fault request in the clear cycle keeps the fault.
  logic fault;
  always_ff @(posedge mclk_in) begin
    if (rst_in) fault <= 1'b0;
    else if (ext_flt) fault <= 1'b1;
    else if (fclr_rise) fault <= 1'b0;
  end

  // ==========================================================================
  // Power state machine.
  dps_pkg::dps_state_t state;
  dps_pkg::dps_state_t next_state;
  logic [7:0]  phase_cnt;
  logic [31:0] spd;
  logic        init_ok;
  wire can_run  = en_bit & hw_en & ~fault;
  wire ramp_off = stop_ramp == 16'h0000;
  assign reinit_go = state == dps_pkg::ST_OFF && can_run && offl_chg;

  always_comb begin
    next_state = state;
    unique case (state)
      dps_pkg::ST_INIT:
        if (phase_cnt == dps_pkg::INIT_CYC) begin
          next_state = can_run ? dps_pkg::ST_RUN : dps_pkg::ST_OFF;
        end
      dps_pkg::ST_OFF:
        if (can_run) begin
          next_state = offl_chg ? dps_pkg::ST_INIT : dps_pkg::ST_RUN;
        end
      dps_pkg::ST_RUN:
        if (fault || !hw_en) begin
          next_state = dps_pkg::ST_OFF;
        end else if (!en_bit) begin
          if (!ramp_off || cfg_servo) next_state = dps_pkg::ST_STOP;
          else if (cfg_dcb) next_state = dps_pkg::ST_DCB;
          else next_state = dps_pkg::ST_OFF;
        end else if (estop_rise) begin
          next_state = dps_pkg::ST_ESTOP;
        end
      dps_pkg::ST_STOP:
        if (fault || !hw_en || spd == 32'h0000_0000) begin
          next_state = dps_pkg::ST_OFF;
        end
      dps_pkg::ST_ESTOP:
        if (fault || !hw_en || !en_bit) begin
          next_state = dps_pkg::ST_OFF;
        end
      dps_pkg::ST_DCB:
        if (fault || !hw_en || phase_cnt == dps_pkg::DCB_TICKS) begin
          next_state = dps_pkg::ST_OFF;
        end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state     <= dps_pkg::ST_INIT;
      phase_cnt <= '0;
      init_ok   <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state) phase_cnt <= '0;
      else if (state == dps_pkg::ST_INIT || (state == dps_pkg::ST_DCB && tick))
        phase_cnt <= phase_cnt + 1'b1;
      if (state == dps_pkg::ST_INIT) init_ok <= phase_cnt == dps_pkg::INIT_CYC;
    end
  end

  wire power_on = state inside {dps_pkg::ST_RUN, dps_pkg::ST_STOP,
                                dps_pkg::ST_ESTOP, dps_pkg::ST_DCB};

  // ==========================================================================
  // Positioning jobs and profile motion.
  logic signed [31:0] prof_pos;
  logic signed [31:0] job_tgt;
  logic signed [31:0] pend_tgt;
  logic               dir_neg;
  logic               job_busy;
  logic               pend_valid;
  logic               pause;
  logic               ref_def;
  logic               reached;

  wire signed [31:0] new_tgt = abs_bit ? $signed(target) : prof_pos + $signed(target);
  wire signed [31:0] rem     = job_tgt - prof_pos;
  wire [31:0] rem_mag  = rem[31] ? 32'(-rem) : 32'(rem);
  wire [31:0] vmag     = vel_ref[31] ? 32'(-vel_ref) : 32'(vel_ref);
  wire [31:0] vint     = {16'h0000, vmag[31:16]};
  wire [31:0] decel    = (cfg_servo && ramp_off) ? dps_pkg::TORQUE_STEP
                       : {stop_ramp, 16'h0000};
  wire [31:0] spd_int  = {16'h0000, spd[31:16]};
  wire signed [31:0] move = dir_neg ? -$signed(spd_int) : $signed(spd_int);
  wire in_run   = state == dps_pkg::ST_RUN;
  wire auto_ok  = auto_bit & ref_def;
  wire want_run = in_run & job_busy & feed_ok & ~pause;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prof_pos   <= '0;
      job_tgt    <= '0;
      pend_tgt   <= '0;
      dir_neg    <= 1'b0;
      spd        <= '0;
      job_busy   <= 1'b0;
      pend_valid <= 1'b0;
      pause      <= 1'b0;
      ref_def    <= 1'b0;
      reached    <= 1'b0;
    end else if (!power_on) begin
      spd        <= '0;
      job_busy   <= 1'b0;
      pend_valid <= 1'b0;
      pause      <= 1'b0;
    end else if (in_run && start_rise && !auto_bit && !job_busy) begin
      prof_pos <= '0;
      ref_def  <= 1'b1;
    end else if (in_run && start_rise && auto_ok) begin
      if (!job_busy || ovr_bit) begin
        job_busy <= 1'b1;
        job_tgt  <= new_tgt;
        reached  <= 1'b0;
      end else begin
        pend_valid <= 1'b1;
        pend_tgt   <= new_tgt;
      end
    end else if (tick) begin
      if (pause) begin
        pause <= 1'b0;
        if (pend_valid) begin
          pend_valid <= 1'b0;
          job_busy   <= 1'b1;
          job_tgt    <= pend_tgt;
          reached    <= 1'b0;
        end
      end else if (want_run && rem_mag <= vint) begin
        prof_pos <= job_tgt;
        spd      <= '0;
        job_busy <= 1'b0;
        reached  <= 1'b1;
        pause    <= 1'b1;
      end else if (want_run) begin
        spd      <= vmag;
        dir_neg  <= rem[31];
        prof_pos <= prof_pos + move;
      end else begin
        // Braking by decel (stop ramp, or TORQUE_STEP with servo and a zero ramp) while feed hold, stop or emergency stop.
        spd      <= (spd > decel) ? spd - decel : 32'h0000_0000;
        prof_pos <= prof_pos + move;
      end
    end
  end

  // ==========================================================================
  // Outputs and status word.
  wire signed [31:0] lag = prof_pos - measured_position_in;
  wire [31:0] lag_mag = lag[31] ? 32'(-lag) : 32'(lag);
  wire [31:0] mspd    = measured_speed_in[31] ? 32'(-measured_speed_in)
                      : 32'(measured_speed_in);
  wire still    = mspd < {still_win, 16'h0000};
  wire dcb_flag = state == dps_pkg::ST_DCB && !cfg_servo;

  dps_pkg::dps_status_t next_status;
  assign next_status.w01 = {din[0], din[1], din[2], din[3], 1'b0,
                            digital_output_1_out, digital_output_0_out,
                            hw_en,
                            init_ok & ~offl_chg & ~fault,
                            dcb_flag, still, power_on,
                            vel_clamped, reached,
                            net_started_in, fault};
  assign next_status.b2  = {lag_mag > {16'h0000, follow_tol},
                            2'b00, feed_ok, 1'b0, job_busy,
                            auto_ok, ref_def};
  assign next_status.b3  = 8'h00;
  assign next_status.pos = measured_position_in;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      status_word_out      <= '0;
      digital_output_0_out <= 1'b0;
      digital_output_1_out <= 1'b0;
      power_stage_on_out   <= 1'b0;
      prdata_out           <= '0;
    end else begin
      status_word_out      <= next_status;
      digital_output_0_out <= ctrl.w01[dps_pkg::CW_DO0];
      digital_output_1_out <= ctrl.w01[dps_pkg::CW_DO1];
      power_stage_on_out   <= power_on;
      if (setup && !pwrite_in) begin
        prdata_out <= hit_ctrl ? ctrl
                    : hit_tgt  ? target
                    : hit_vel  ? vel_ref
                    : hit_ramp ? {16'h0000, stop_ramp}
                    : hit_win  ? {16'h0000, still_win}
                    : hit_tol  ? {16'h0000, follow_tol}
                    : hit_cfg  ? {29'h0, offl_chg, cfg_dcb, cfg_servo}
                    : hit_slo  ? status_word_out[31:0]
                    : hit_shi  ? status_word_out.pos
                    : 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_job_done;
    $fell(job_busy) && pend_valid && !power_on == 1'b0;
  endsequence
  sequence s_estop_hold;
    state == dps_pkg::ST_ESTOP && can_run;
  endsequence

  AST_FAULT_SET: assert property (ext_flt |-> ##2 status_word_out.w01[0])
    else $error("fault request not shown in status");
  AST_NET: assert property (status_word_out.w01[1] == $past(net_started_in))
    else $error("network state bit wrong");
  AST_POWER: assert property (status_word_out.w01[4] == $past(power_on))
    else $error("power stage bit wrong");
  AST_VEL_LIMIT: assert property (vel_ref <= dps_pkg::VEL_MAX
                                  && vel_ref >= dps_pkg::VEL_MIN)
    else $error("velocity reference out of range");
  AST_VACANT: assert property (!status_word_out.w01[11] && status_word_out.b3 == 8'h00
                               && status_word_out.b2[6:5] == 2'b00 && !status_word_out.b2[3])
    else $error("vacant status bit set");
  AST_POS: assert property (status_word_out.pos == $past(measured_position_in))
    else $error("position bytes wrong");
  AST_DIN: assert property (status_word_out.w01[15:12]
                            == $past({din[0], din[1], din[2], din[3]}))
    else $error("input mirror wrong");
  AST_ESTOP: assert property (s_estop_hold |=> state == dps_pkg::ST_ESTOP)
    else $error("emergency stop left while enabled");
  AST_STOP: assert property (in_run && !en_bit && hw_en && !fault && !ramp_off
                             |=> state == dps_pkg::ST_STOP)
    else $error("disable did not start the stop ramp");
  AST_PAUSE: assert property (s_job_done |-> !job_busy [*2])
    else $error("queued job started without a pause");
  AST_REF: assert property (job_busy |-> ref_def)
    else $error("job running without reference point");

endmodule : dps_status

// [test/dps_master.sv]
// APB master standing in for the fieldbus master that writes control data.
// Assumes the slave clock and a slave that may stretch the access phase.
`timescale 1ns/100ps
module dps_master (
  input  wire logic        mclk_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [7:0]       paddr_out,
  output logic [31:0]      pwdata_out,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in
);
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0000_0000;
  end
  // ==========================================================================
  // One transfer; a released data bus shows the inverse of the last value.
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                      output logic [31:0] rd, output logic err);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= addr;
    pwdata_out <= data;
    @(posedge mclk_in);
    penable_out <= 1'b1;
    // Only the bench timeout ends a wait for the answer.
    do begin
      @(posedge mclk_in);
    end while (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    pwdata_out <= ~data;
    @(posedge mclk_in);
  endtask : xfer
endmodule : dps_master

// [test/test_drive_position_status_word.sv]
// Self-checking bench of the drive position status block.
// Assumes the partner APB master in dps_master and a short evaluation tick.
`timescale 1ns/100ps
module test_drive_position_status_word;
  typedef struct packed { logic [31:0] v; logic [31:0] m; } dps_note_t;
  localparam logic [31:0] EN = 32'h1, ES = 32'h4, EXT = 32'h8, FC = 32'h80;
  localparam logic [31:0] AUTO = 32'h1_0000, START = 32'h2_0000, FEED = 32'h8_0000;
  localparam logic [31:0] ABS = 32'h10_0000;
  logic mclk_in = 1'b0, rst_in = 1'b1, psel, penable, pwrite, pready, pslverr, err;
  logic hw_en = 1'b0, net = 1'b0, do0, do1, pwr;
  logic [3:0] din = 4'h0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, got, seed = 32'h0000_4a71, r;
  logic signed [31:0] pos = 32'sh0, spd = 32'sh0;
  dps_pkg::dps_status_t stat;
  dps_note_t notes[$], note;
  logic [31:0] seen_q[$];
  int bad_count = 0, checked = 0, cyc = 0, i;
  logic [31:0] vin[3] = '{32'h7fff_ffff, 32'h8000_0000, 32'h0444_0000};
  logic [31:0] vout[3] = '{dps_pkg::VEL_MAX, dps_pkg::VEL_MIN, 32'h0444_0000};
  always #2 mclk_in = ~mclk_in;
  dps_status #(.EVAL_CYCLES(20)) i_dps_status (.mclk_in(mclk_in), .rst_in(rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .hardware_enable_input_in(hw_en), .digital_input_in(din), .net_started_in(net),
    .measured_position_in(pos), .measured_speed_in(spd), .digital_output_0_out(do0),
    .digital_output_1_out(do1), .power_stage_on_out(pwr), .status_word_out(stat));
  dps_master i_dps_master (.mclk_in(mclk_in), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata),
    .pready_in(pready), .pslverr_in(pslverr));
  // ==========================================================================
  // Helpers.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic look(input logic [31:0] val, input logic [31:0] ev, input logic [31:0] em);
    notes.push_back('{ev, em});
    seen_q.push_back(val);
  endtask : look
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_dps_master.xfer(1'b1, a, d, rdv, err);
    repeat (4) @(posedge mclk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_dps_master.xfer(1'b0, a, 32'h0, rdv, err);
  endtask : rd
  task automatic results();
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // ==========================================================================
  // Compares each observed result with the oldest note.
  always @(negedge mclk_in) begin
    while (seen_q.size() > 0) begin
      got = seen_q.pop_front();
      note = notes.pop_front();
      checked++;
      if ((got & note.m) !== (note.v & note.m)) begin
        bad_count++;
        $display("wrong value at %0t: got %h want %h", $time, got, note.v);
      end
    end
  end
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      results();
    end
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (40) @(posedge mclk_in);
    look(stat[31:0], 32'h0000_00a0, 32'hff69_fffb);
    for (i = 0; i < 6; i++) begin
      r = rnd();
      din <= r[3:0];
      hw_en <= r[4];
      net <= r[5];
      pos <= rnd();
      spd <= i[0] ? 32'sh0100_0000 : 32'sh0;
      repeat (6) @(posedge mclk_in);
      look(stat[31:0], {8'h0, (pos < 0 ? -pos : pos) > {16'h0, dps_pkg::RST_TOL}, 7'h0,
           r[0], r[1], r[2], r[3], 3'h0, r[4], 2'h0, !i[0], 3'h0, r[5], 1'b0},
           32'h0080_f122);
      look(stat.pos, pos, 32'hffff_ffff);
      rd(dps_pkg::ADDR_STAT_HI);
      look(rdv, pos, 32'hffff_ffff);
    end
    rd(8'h1c);
    look({err, rdv[30:0]}, 32'h8000_0000, 32'hffff_ffff);
    for (i = 0; i < 3; i++) begin
      wr(dps_pkg::ADDR_VEL, vin[i]);
      rd(dps_pkg::ADDR_VEL);
      look(rdv, vout[i], 32'hffff_ffff);
      look(stat[31:0], {28'h0, i < 2, 3'h0}, 32'h8);
    end
    for (i = 1; i < 3; i++) begin
      wr(dps_pkg::ADDR_CTRL, {16'h0, i[0], i[1], 14'h0});
      look({do1, do0, 5'h0, stat[10:9]}, {i[1], i[0], 5'h0, i[1], i[0]}, 32'h1ff);
    end
    wr(dps_pkg::ADDR_CTRL, EXT);
    look(stat[31:0], 32'h1, 32'h81);
    wr(dps_pkg::ADDR_CTRL, 32'h0);
    wr(dps_pkg::ADDR_CTRL, FC);
    look(stat[31:0], 32'h80, 32'h81);
    hw_en <= 1'b1;
    pos <= 32'sh0;
    wr(dps_pkg::ADDR_CTRL, EN);
    for (i = 0; i < 500 && pwr !== 1'b1; i++) @(posedge mclk_in);
    look({pwr, stat[4]}, 32'h3, 32'h3);
    wr(dps_pkg::ADDR_CTRL, EN | START);
    repeat (60) @(posedge mclk_in);
    look(stat[31:0], 32'h1_0000, 32'h1_0000);
    wr(dps_pkg::ADDR_CTRL, EN | AUTO | FEED);
    repeat (60) @(posedge mclk_in);
    look(stat[31:0], 32'h13_0000, 32'hfb_0000);
    wr(dps_pkg::ADDR_TARGET, 32'h0000_2000);
    wr(dps_pkg::ADDR_CTRL, EN | AUTO | FEED | ABS | START);
    look(stat[31:0], 32'h4_0000, 32'h4_0004);
    // A second start without overwrite queues behind the running job.
    wr(dps_pkg::ADDR_CTRL, EN | AUTO | FEED | ABS);
    wr(dps_pkg::ADDR_CTRL, EN | AUTO | FEED | ABS | START);
    repeat (400) @(posedge mclk_in);
    look(stat[31:0], 32'h93_0004, 32'hff_0004);
    wr(dps_pkg::ADDR_CTRL, EN | AUTO | FEED | ES);
    repeat (400) @(posedge mclk_in);
    look({31'h0, pwr}, 32'h1, 32'h1);
    wr(dps_pkg::ADDR_CTRL, 32'h0);
    for (i = 0; i < 20000 && pwr !== 1'b0; i++) @(posedge mclk_in);
    look({30'h0, pwr, stat[4]}, 32'h0, 32'h3);
    @(negedge mclk_in);
    @(posedge mclk_in);
    results();
  end
endmodule : test_drive_position_status_word
